/* File: tpsdp_pkg.sv */
// Package of constants and types for the test point strap debug port.
// Functional notes
// R1: Test points high-impedance while reset asserted.
// R2: Sample test points 1.5 us after release.
// R3: Drive test points only after capture.
// R4: Captured test point straps set configuration.
// R5: Sample three aux straps, then drive them.
// R6: Aux strap value selects initial debug pattern.
// R7: Value x111 keeps test points high-impedance.
// R8: Board leaves aux straps x111 normally.
// R9: Value x010 drives fixed clock pattern.
// R10: Software may change selection any time; the code takes writes only in TPSDP_RUN and drops earlier ones.
// R11: Board should jumper aux straps to pull-down.
// R12: Captured straps hold until next reset.
package tpsdp_pkg;
	localparam int TP_WIDTH = 8;
	localparam int AUX_WIDTH = 3;
	localparam int CLK_MHZ = 100;
	// Strap sample delay after reset release, in nanoseconds.
	localparam int SAMPLE_DELAY_NS = 1500;
	localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS * CLK_MHZ) / 1000;
	localparam int CNT_WIDTH = 9;
	localparam logic [2:0] SEL_IDLE = 3'h7;
	localparam logic [2:0] SEL_CLOCKS = 3'h2;
	localparam logic [7:0] TP_STRAP_RESET = 8'h00;
	localparam logic [2:0] AUX_STRAP_RESET = 3'h7;
	// Divider depth; each stage halves the base debug clock once more.
	localparam int DIV_WIDTH = 4;

	typedef enum logic [1:0] {
		TPSDP_WAIT,
		TPSDP_CAPTURE,
		TPSDP_RUN
	} tpsdp_state_type;

	typedef struct packed {
		logic [7:0] tp_straps;
		logic [2:0] aux_straps;
		logic valid;
	} tpsdp_straps_type;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} tpsdp_pins_type;
endpackage

/* File: tpsdp_clkgen.sv */
// Divided debug clocks derived from a base debug clock input.
`timescale 1ns/10ps
module tpsdp_clkgen (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Debug clock base, already synchronous to i_clk
	input wire logic i_base_tick,
	// Divided clocks
	output logic [tpsdp_pkg::DIV_WIDTH-1:0] o_div
);
	logic [tpsdp_pkg::DIV_WIDTH-1:0] div_q;

	// Each bit halves the previous one, so bit n runs at base / 2^(n+1).
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			div_q <= '0;
		end else if (i_base_tick) begin
			div_q <= div_q + 1'b1;
		end
	end

	assign o_div = div_q;
endmodule

/* File: tpsdp_top.sv */
// Test point strap capture and debug output selection.
`timescale 1ns/10ps
module tpsdp_top (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Test point port pins
	input wire logic [7:0] i_test_point_port,
	output logic [7:0] o_test_point_port,
	output logic [7:0] o_test_point_port_oe,
	// Auxiliary scan output strap pins
	input wire logic [2:0] i_aux_scan_out_straps,
	output logic [2:0] o_aux_scan_out_straps,
	output logic [2:0] o_aux_scan_out_straps_oe,
	// Normal scan data to drive on the aux pins once straps are taken
	input wire logic [2:0] i_scan_data,
	// Base debug clock pulses (one cycle high per base period, same clock)
	input wire logic i_dbg_base_tick,
	// Software selection of the test point pattern
	input wire logic i_sw_sel_write,
	input wire logic [2:0] i_sw_sel,
	// Captured straps and selection
	output tpsdp_pkg::tpsdp_straps_type o_straps,
	output logic [2:0] o_sel
);
	tpsdp_pkg::tpsdp_state_type state_q;
	logic [tpsdp_pkg::CNT_WIDTH-1:0] cnt_q;
	logic [7:0] tp_sync1_q;
	logic [7:0] tp_sync2_q;
	logic [2:0] aux_sync1_q;
	logic [2:0] aux_sync2_q;
	tpsdp_pkg::tpsdp_straps_type straps_q;
	logic [2:0] sel_q;
	tpsdp_pkg::tpsdp_pins_type pins_d;
	tpsdp_pkg::tpsdp_pins_type pins_q;
	logic [tpsdp_pkg::DIV_WIDTH-1:0] div;

	localparam logic [tpsdp_pkg::CNT_WIDTH-1:0] CNT_LAST =
		tpsdp_pkg::CNT_WIDTH'(tpsdp_pkg::SAMPLE_DELAY_CYC - 1);

	// Two-flop synchronisers on the strap pins.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tp_sync1_q <= '0;
			tp_sync2_q <= '0;
			aux_sync1_q <= '0;
			aux_sync2_q <= '0;
		end else begin
			tp_sync1_q <= i_test_point_port;
			tp_sync2_q <= tp_sync1_q;
			aux_sync1_q <= i_aux_scan_out_straps;
			aux_sync2_q <= aux_sync1_q;
		end
	end

	// Sequencer: wait the sample delay, capture once, then run.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_q <= tpsdp_pkg::TPSDP_WAIT;
			cnt_q <= '0;
		end else begin
			case (state_q)
				tpsdp_pkg::TPSDP_WAIT: begin
					// R2
					if (cnt_q == CNT_LAST) begin
						state_q <= tpsdp_pkg::TPSDP_CAPTURE;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				tpsdp_pkg::TPSDP_CAPTURE: begin
					state_q <= tpsdp_pkg::TPSDP_RUN;
				end
				default: begin
					state_q <= tpsdp_pkg::TPSDP_RUN;
				end
			endcase
		end
	end

	// Strap capture; the values then hold until the next reset.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			straps_q.tp_straps <= tpsdp_pkg::TP_STRAP_RESET;
			straps_q.aux_straps <= tpsdp_pkg::AUX_STRAP_RESET;
			straps_q.valid <= 1'b0;
		end else if (state_q == tpsdp_pkg::TPSDP_CAPTURE) begin
			straps_q.tp_straps <= tp_sync2_q; // R2 R4
			straps_q.aux_straps <= aux_sync2_q; // R5
			straps_q.valid <= 1'b1;
		end // R12
	end

	// Selection: straps give the initial value, software may rewrite it.
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sel_q <= tpsdp_pkg::SEL_IDLE;
		end else if (state_q == tpsdp_pkg::TPSDP_CAPTURE) begin
			sel_q <= aux_sync2_q; // R6
		end else if (state_q == tpsdp_pkg::TPSDP_RUN && i_sw_sel_write) begin
			sel_q <= i_sw_sel; // R10
		end
	end

	tpsdp_clkgen u_clkgen (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_base_tick(i_dbg_base_tick),
		.o_div(div)
	);

	// Pattern decode. Only the exact clock code drives; all else stays idle.
	always_comb begin
		pins_d.out = '0;
		pins_d.oe = '0;
		if (state_q == tpsdp_pkg::TPSDP_RUN) begin // R3
			if (sel_q[1:0] == tpsdp_pkg::SEL_CLOCKS[1:0] && !sel_q[2]) begin
				// R9: base, /2, /8, low, /4, base, low, low.
				pins_d.oe = 8'hFF;
				pins_d.out = {1'b0, 1'b0, i_dbg_base_tick, div[1], 1'b0,
					div[2], div[0], i_dbg_base_tick};
			end else begin
				// R7: idle and unknown patterns leave the port undriven.
				pins_d.oe = 8'h00;
			end
		end // R1
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			pins_q <= '0; // R1
		end else begin
			pins_q <= pins_d;
		end
	end

	assign o_test_point_port = pins_q.out;
	assign o_test_point_port_oe = pins_q.oe;
	// R5: aux pins become scan outputs once their straps are taken.
	assign o_aux_scan_out_straps = straps_q.valid ? i_scan_data : 3'h0;
	assign o_aux_scan_out_straps_oe = {3{straps_q.valid}};
	assign o_straps = straps_q;
	assign o_sel = sel_q;
endmodule

/* File: tpsdp_board.sv */
// Board strap resistors seen on pins that the device leaves undriven.
`timescale 1ns/10ps
module tpsdp_board #(parameter int W = 8) (
	// Device side of the pins
	input wire logic [W-1:0] i_out,
	input wire logic [W-1:0] i_oe,
	// Strap level and resulting pin level
	input wire logic [W-1:0] i_strap,
	output logic [W-1:0] o_pin
);
	// A released pin falls back to its strap resistor, never the last value.
	assign o_pin = (i_out & i_oe) | (i_strap & ~i_oe);
endmodule

/* File: tpsdp_top_properties.sv */
// Checker of strap capture, pin enables and pattern selection.
`timescale 1ns/10ps
module tpsdp_chk (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_sw_sel_write,
	input wire logic [2:0] i_sw_sel,
	input wire logic [2:0] i_scan_data,
	input wire logic [7:0] o_test_point_port,
	input wire logic [7:0] o_test_point_port_oe,
	input wire logic [2:0] o_aux_scan_out_straps,
	input wire logic [2:0] o_aux_scan_out_straps_oe,
	input wire tpsdp_pkg::tpsdp_straps_type o_straps,
	input wire logic [2:0] o_sel
);
	logic [8:0] cnt_q;
	logic v;
	assign v = o_straps.valid;
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) cnt_q <= 9'h000;
		else if (!v) cnt_q <= cnt_q + 9'h001;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	a_oe_before_cap: assert property (!v |->
		{o_test_point_port_oe, o_aux_scan_out_straps_oe} == 11'h000)
		else $error("pin driven before capture");
	a_cap_time: assert property ($rose(v) |-> cnt_q == 9'h097)
		else $error("capture edge wrong");
	a_straps_hold: assert property (v |=> $stable(o_straps))
		else $error("straps changed");
	a_sel_init: assert property ($rose(v) |-> o_sel == o_straps.aux_straps)
		else $error("initial selection wrong");
	a_aux_drive: assert property (v |-> o_aux_scan_out_straps == i_scan_data
		&& o_aux_scan_out_straps_oe == 3'h7) else $error("aux pins");
	a_idle_hiz: assert property (v && o_sel == 3'h7 |=>
		o_test_point_port_oe == 8'h00) else $error("idle pattern driven");
	a_clk_pattern: assert property (v && o_sel == 3'h2 |=>
		o_test_point_port_oe == 8'hFF && (o_test_point_port & 8'hC8) == 8'h00
		&& o_test_point_port[5] == o_test_point_port[0])
		else $error("clock pattern");
	a_sw_write: assert property (v && i_sw_sel_write |=>
		o_sel == $past(i_sw_sel)) else $error("selection write");
endmodule
bind tpsdp_top tpsdp_chk u_tpsdp_chk (.*);

/* File: tb_top.sv */
// Self-checking bench for strap capture and debug pattern selection.
`timescale 1ns/10ps
module tb_top;
	logic clk = 0, rst_n = 0, wr = 0, tick = 0, vp = 0, wp = 0;
	logic [7:0] tps = 8'h00, tp, tpo, tpoe;
	logic [2:0] axs = 3'h7, ax, axo, axoe, sd = 3'h0, sel = 3'h0, osel, s;
	tpsdp_pkg::tpsdp_straps_type st;
	logic [14:0] q[$];
	logic [2:0] ea;
	int n_errors = 0, comparisons = 0, cyc = 0;
	always #5 clk = ~clk;
	tpsdp_top u_tpsdp_top (.i_clk(clk), .i_reset_n(rst_n),
		.i_test_point_port(tp), .o_test_point_port(tpo),
		.o_test_point_port_oe(tpoe), .i_aux_scan_out_straps(ax),
		.o_aux_scan_out_straps(axo), .o_aux_scan_out_straps_oe(axoe),
		.i_scan_data(sd), .i_dbg_base_tick(tick), .i_sw_sel_write(wr),
		.i_sw_sel(sel), .o_straps(st), .o_sel(osel));
	tpsdp_board #(8) u_tpsdp_board (.i_out(tpo), .i_oe(tpoe),
		.i_strap(tps), .o_pin(tp));
	tpsdp_board #(3) u_tpsdp_board_aux (.i_out(axo), .i_oe(axoe),
		.i_strap(axs), .o_pin(ax));
	task automatic chk(string n, logic [14:0] e, logic [14:0] g);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		tick <= ~tick;
		sd <= 3'($urandom);
	end
	always @(negedge clk) begin
		if (st.valid === 1'b1 && !vp) chk("straps", q.pop_front(), {st, osel});
		if (wp) chk("sel", q.pop_front(), {12'h000, osel});
		vp <= st.valid === 1'b1;
		wp <= wr && st.valid === 1'b1;
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			n_errors++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(73801));
		for (int r = 0; r < 3; r++) begin
			@(posedge clk);
			rst_n <= 1'b0;
			tps <= 8'($urandom);
			axs <= r == 0 ? 3'h7 : r == 1 ? 3'h2 : 3'($urandom);
			repeat (3) @(posedge clk);
			chk("oe_reset", 15'h0000, {4'h0, tpoe, axoe});
			q.push_back({tps, axs, 1'b1, axs});
			ea = axs;
			rst_n <= 1'b1;
			@(posedge clk);
			// Early write must be ignored, so selection still comes from straps.
			wr <= 1'b1;
			sel <= 3'h0;
			@(posedge clk);
			wr <= 1'b0;
			wait (st.valid === 1'b1);
			@(posedge clk);
			tps <= ~tps;
			axs <= ~axs;
			repeat (2) @(negedge clk);
			chk("oe_run", {4'h0, ea == 3'h2 ? 8'hFF : 8'h00, 3'h7},
				{4'h0, tpoe, axoe});
			for (int k = 0; k < 2; k++) begin
				@(posedge clk);
				s = k == 1 ? 3'h2 : 3'($urandom);
				wr <= 1'b1;
				sel <= s;
				q.push_back({12'h000, s});
			end
			@(posedge clk);
			wr <= 1'b0;
			repeat (2) @(negedge clk);
			chk("oe_sw", 15'h07FF, {4'h0, tpoe, axoe});
		end
		end_of_test();
	end
endmodule
